// >>> verilog/ltc_core.sv
/*
   LIN transceiver control: transmitter gating, fault detection with latched
   status, bitrate select, receive-only mode, standby wake-up, APB registers
   and a level interrupt.
   Assumes all inputs synchronous to core_clk, reset asserted at power-on.
*/
// Design decisions made here: the address map and the APB interface to the registers.
module ltc_core
   import ltc_pkg::*;
#(
   parameter int TDOM_TX_CYC = LTC_TDOM_TX_CYC,
   parameter int TLIN_CYC = LTC_TLIN_CYC,
   parameter int TDOM_BUS_CYC = LTC_TDOM_BUS_CYC,
   parameter int TWAKE_CYC = LTC_TWAKE_DOM_CYC,
   parameter int TLINBUS_CYC = LTC_TLINBUS_CYC
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic txd_in,
   input wire logic bus_rx,
   input wire logic thermal_shutdown_stage_one,
   input wire logic supply_fault,
   output logic tx_drive_enable,
   output logic bus_tx,
   output logic rxd_out,
   output logic rx_enable,
   output logic fast_rate_out,
   output logic wake_out,
   output logic irq
);
   logic [2:0] cfg_r;
   logic [2:0] ctrl_r;
   logic [LTC_NSTAT-1:0] stat_r;
   logic [LTC_NSTAT-1:0] stat_nxt;
   logic [LTC_NSTAT-1:0] ien_r;
   ltc_mode_t mode_r;
   ltc_mode_t mode_nxt;
   logic txd_d_r;
   logic follow_pend_r;
   logic [31:0] rdata_nxt;

   wire fast_rate_enable = cfg_r[LTC_CFG_FAST];
   wire tx_timeout_detect_enable = cfg_r[LTC_CFG_TOUT];
   wire wake_type_select = cfg_r[LTC_CFG_WAKE];
   wire receive_only_enable = ctrl_r[LTC_CTRL_RXONLY];
   wire flash_mode = ctrl_r[LTC_CTRL_FLASH];
   wire permanent_recessive_flag = stat_r[LTC_STS_PREC];
   wire permanent_dominant_flag = stat_r[LTC_STS_PDOM];

   wire wr_acc = psel && penable && pwrite;
   wire rd_acc = psel && penable && !pwrite;
   wire a_cfg = paddr == LTC_CFG_OFS;
   wire a_ctrl = paddr == LTC_CTRL_OFS;
   wire a_stat = paddr == LTC_STAT_OFS;
   wire a_clr = paddr == LTC_CLR_OFS;
   wire a_ien = paddr == LTC_IEN_OFS;
   wire a_state = paddr == LTC_STATE_OFS;
   wire a_any = a_cfg || a_ctrl || a_stat || a_clr || a_ien || a_state;
   wire [LTC_NSTAT-1:0] clr_vec = (wr_acc && a_clr) ? pwdata[LTC_NSTAT-1:0] : '0;

   // Fault and wake timers, all parameterised cycle counts
   logic tx_dom_exp;
   logic follow_exp;
   logic bus_dom_exp;
   logic wake_dom_exp;
   logic wake_lvl_exp;
   wire active = mode_r == LTC_ACTIVE;
   wire follow_run = follow_pend_r && bus_rx;
   wire wake_lvl = (mode_r == LTC_STBY_REC) ? !bus_rx : bus_rx;

   ltc_lowcnt #(.LIMIT(TDOM_TX_CYC)) u_txdom (
      .core_clk(core_clk), .reset(reset),
      .run(active && !txd_in && tx_timeout_detect_enable),
      .expired(tx_dom_exp));
   ltc_lowcnt #(.LIMIT(TLIN_CYC)) u_follow (
      .core_clk(core_clk), .reset(reset), .run(follow_run), .expired(follow_exp));
   ltc_lowcnt #(.LIMIT(TDOM_BUS_CYC)) u_busdom (
      .core_clk(core_clk), .reset(reset), .run(active && !bus_rx),
      .expired(bus_dom_exp));
   ltc_lowcnt #(.LIMIT(TWAKE_CYC)) u_wdom (
      .core_clk(core_clk), .reset(reset), .run(!active && !bus_rx),
      .expired(wake_dom_exp));
   ltc_lowcnt #(.LIMIT(TLINBUS_CYC)) u_wlvl (
      .core_clk(core_clk), .reset(reset), .run(!active && wake_lvl),
      .expired(wake_lvl_exp));

   // Pattern wake needs the dominant phase long enough and then recessive
   logic pat_armed_r;
   wire pattern_wake = pat_armed_r && bus_rx;
   wire change_wake = wake_lvl_exp;
   wire wake_evt = !active && (wake_type_select ? change_wake : pattern_wake);

   // Sticky status bit: a hardware set beats a software clear in the same
   // cycle, but the clear acts in both access cycles, so an event in the first is lost
   function automatic logic sticky_next(input logic set, input logic cur,
      input logic clr);
      return set || (cur && !clr);
   endfunction

   // Software reads status and clears it with write-one
   assign stat_nxt[LTC_STS_TXDOM] = sticky_next(tx_dom_exp, stat_r[LTC_STS_TXDOM],
      clr_vec[LTC_STS_TXDOM]);
   assign stat_nxt[LTC_STS_PREC] = sticky_next(follow_exp, permanent_recessive_flag,
      clr_vec[LTC_STS_PREC]);
   assign stat_nxt[LTC_STS_PDOM] = sticky_next(bus_dom_exp, permanent_dominant_flag,
      clr_vec[LTC_STS_PDOM]);
   assign stat_nxt[LTC_STS_WAKE] = sticky_next(wake_evt, stat_r[LTC_STS_WAKE],
      clr_vec[LTC_STS_WAKE]);

   // Transmit gating: latched timeout and recessive faults, live faults, receive-only, standby
   // Live faults gate directly and need no clear; only latched ones wait
   // for software, so a thermal event never leaves a stale block behind
   wire tx_block = stat_r[LTC_STS_TXDOM] || permanent_recessive_flag ||
      thermal_shutdown_stage_one || supply_fault ||
      receive_only_enable || !active;
   // Fast rate from config bit, forced while flashing
   wire fast_nxt = fast_rate_enable || flash_mode;

   always_comb begin
      mode_nxt = mode_r;
      if (active && wr_acc && a_ctrl && pwdata[LTC_CTRL_STBY]) begin
         mode_nxt = bus_rx ? LTC_STBY_REC : LTC_STBY_DOM;
      end else if (wake_evt) begin
         mode_nxt = LTC_ACTIVE;
      end
   end

   assign rdata_nxt = a_cfg ? {29'h0, cfg_r} :
      a_ctrl ? {29'h0, ctrl_r} :
      a_stat ? {28'h0, stat_r} :
      a_ien ? {28'h0, ien_r} :
      a_state ? {30'h0, mode_r} : 32'h0;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         cfg_r <= LTC_CFG_RST;
         ctrl_r <= LTC_CTRL_RST;
         stat_r <= '0;
         ien_r <= '0;
         mode_r <= LTC_ACTIVE;
         txd_d_r <= 1'b1;
         follow_pend_r <= 1'b0;
         pat_armed_r <= 1'b0;
      end else begin
         if (wr_acc && a_cfg) cfg_r <= pwdata[2:0];
         if (wr_acc && a_ctrl) ctrl_r <= {pwdata[LTC_CTRL_FLASH], 1'b0,
            pwdata[LTC_CTRL_RXONLY]};
         if (wr_acc && a_ien) ien_r <= pwdata[LTC_NSTAT-1:0];
         stat_r <= stat_nxt;
         mode_r <= mode_nxt;
         txd_d_r <= txd_in;
         // Window opens on a driven falling edge, closes when bus follows
         if (txd_d_r && !txd_in && !tx_block) follow_pend_r <= 1'b1;
         else if (!bus_rx || follow_exp || txd_in) follow_pend_r <= 1'b0;
         // Arming stays until wake, a glitch back to recessive then wakes
         if (!active && wake_dom_exp) pat_armed_r <= 1'b1;
         else if (active) pat_armed_r <= 1'b0;
      end
   end

   // Registered bus outputs
   always_ff @(posedge core_clk) begin
      if (reset) begin
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         // One wait state: pready answers in the second access cycle
         pready <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !a_any;
         if (rd_acc && !pready) prdata <= rdata_nxt;
      end
   end

   // Registered link outputs; one cycle of latency on every path
   always_ff @(posedge core_clk) begin
      if (reset) begin
         tx_drive_enable <= 1'b0;
         bus_tx <= 1'b1;
         rxd_out <= 1'b1;
         rx_enable <= 1'b1;
         fast_rate_out <= 1'b0;
         wake_out <= 1'b0;
         irq <= 1'b0;
      end else begin
         tx_drive_enable <= !tx_block;
         bus_tx <= tx_block ? 1'b1 : txd_in;
         rxd_out <= bus_rx;
         rx_enable <= 1'b1;
         fast_rate_out <= fast_nxt;
         wake_out <= wake_evt;
         irq <= |(stat_nxt & ien_r);
      end
   end

   a_tx_blocked_fault: assert property (@(posedge core_clk) disable iff (reset)
      (stat_r[LTC_STS_TXDOM] || permanent_recessive_flag) |=> !tx_drive_enable)
      else $error("transmitter enabled with latched fault");
   a_rx_always_on: assert property (@(posedge core_clk) disable iff (reset)
      rx_enable) else $error("receiver disabled");
   a_flash_forces_fast: assert property (@(posedge core_clk) disable iff (reset)
      flash_mode |=> fast_rate_out) else $error("flash mode without fast rate");
   a_rate_default: assert property (@(posedge core_clk) disable iff (reset)
      (!fast_rate_enable && !flash_mode) |=> !fast_rate_out)
      else $error("fast rate without request");
   a_pdom_keeps_tx: assert property (@(posedge core_clk) disable iff (reset)
      (bus_dom_exp && !tx_block) |=> tx_drive_enable && permanent_dominant_flag)
      else $error("permanent dominant blocked transmitter");
   a_rxonly_blocks: assert property (@(posedge core_clk) disable iff (reset)
      receive_only_enable |=> !tx_drive_enable ##0 rxd_out == $past(bus_rx))
      else $error("receive-only failed");
   a_thermal_blocks: assert property (@(posedge core_clk) disable iff (reset)
      (thermal_shutdown_stage_one || supply_fault) |=> !tx_drive_enable)
      else $error("transmitter on during thermal or supply fault");
   a_timeout_off: assert property (@(posedge core_clk) disable iff (reset)
      (!tx_timeout_detect_enable && !stat_r[LTC_STS_TXDOM] && !clr_vec[LTC_STS_TXDOM]
      && !tx_dom_exp) |=> !stat_r[LTC_STS_TXDOM])
      else $error("timeout flag set while detection off");
   a_wake_active: assert property (@(posedge core_clk) disable iff (reset)
      wake_evt |=> mode_r == LTC_ACTIVE && stat_r[LTC_STS_WAKE])
      else $error("wake did not return to active");

   // Bus handshake: exactly one wait state, answer is a single-cycle pulse
   a_apb_one_wait: assert property (@(posedge core_clk) disable iff (reset)
      (psel && penable && !pready) |=> pready)
      else $error("access not answered after one wait state");
   a_pready_pulse: assert property (@(posedge core_clk) disable iff (reset)
      pready |=> !pready)
      else $error("ready held longer than one cycle");
   a_slverr_unmapped: assert property (@(posedge core_clk) disable iff (reset)
      (psel && penable && !pready && !a_any) |=> pslverr && pready)
      else $error("unmapped access without error response");
   a_irq_level: assert property (@(posedge core_clk) disable iff (reset)
      1'b1 |=> irq == |(stat_r & $past(ien_r)))
      else $error("interrupt does not track enabled status");

   // Link path: receive always forwarded, transmit follows or stays recessive
   a_rx_follows_bus: assert property (@(posedge core_clk) disable iff (reset)
      1'b1 |=> rxd_out == $past(bus_rx))
      else $error("receive data not forwarded");
   a_tx_recessive_blk: assert property (@(posedge core_clk) disable iff (reset)
      tx_block |=> bus_tx && !tx_drive_enable)
      else $error("blocked transmitter drives the bus");
   a_tx_follows_txd: assert property (@(posedge core_clk) disable iff (reset)
      !tx_block |=> tx_drive_enable && bus_tx == $past(txd_in))
      else $error("enabled transmitter does not follow input");
   a_fast_select: assert property (@(posedge core_clk) disable iff (reset)
      fast_rate_enable |=> fast_rate_out)
      else $error("fast rate bit ignored");

   // Fault flags: set on expiry, held until software clears them
   a_txdom_sets: assert property (@(posedge core_clk) disable iff (reset)
      tx_dom_exp |=> stat_r[LTC_STS_TXDOM])
      else $error("dominant timeout not flagged");
   a_timeout_idle: assert property (@(posedge core_clk) disable iff (reset)
      !tx_timeout_detect_enable |=> !tx_dom_exp)
      else $error("timeout counter runs while disabled");
   a_prec_sets: assert property (@(posedge core_clk) disable iff (reset)
      follow_exp |=> permanent_recessive_flag && !follow_pend_r)
      else $error("permanent recessive not flagged");
   a_pdom_sets: assert property (@(posedge core_clk) disable iff (reset)
      bus_dom_exp |=> permanent_dominant_flag)
      else $error("permanent dominant not flagged");
   a_txdom_held: assert property (@(posedge core_clk) disable iff (reset)
      (stat_r[LTC_STS_TXDOM] && !clr_vec[LTC_STS_TXDOM]) |=> stat_r[LTC_STS_TXDOM])
      else $error("timeout flag lost without clear");
   a_prec_held: assert property (@(posedge core_clk) disable iff (reset)
      (permanent_recessive_flag && !clr_vec[LTC_STS_PREC]) |=> permanent_recessive_flag)
      else $error("recessive flag lost without clear");

   // Standby entry, wake filters and the wake pulse
   a_standby_entry: assert property (@(posedge core_clk) disable iff (reset)
      (active && wr_acc && a_ctrl && pwdata[LTC_CTRL_STBY]) |=>
      mode_r == ($past(bus_rx) ? LTC_STBY_REC : LTC_STBY_DOM))
      else $error("standby entered with wrong bus level");
   a_standby_blocks: assert property (@(posedge core_clk) disable iff (reset)
      !active |=> !tx_drive_enable)
      else $error("transmitter enabled in standby");
   a_pattern_wake: assert property (@(posedge core_clk) disable iff (reset)
      (!active && !wake_type_select && pat_armed_r && bus_rx) |=> mode_r == LTC_ACTIVE)
      else $error("pattern wake missed");
   a_change_rec: assert property (@(posedge core_clk) disable iff (reset)
      (mode_r == LTC_STBY_REC && wake_type_select && wake_lvl_exp) |=>
      mode_r == LTC_ACTIVE)
      else $error("dominant level did not wake");
   a_change_dom: assert property (@(posedge core_clk) disable iff (reset)
      (mode_r == LTC_STBY_DOM && wake_type_select && wake_lvl_exp) |=>
      mode_r == LTC_ACTIVE)
      else $error("recessive level did not wake");
   a_wake_pulse: assert property (@(posedge core_clk) disable iff (reset)
      wake_out |=> !wake_out)
      else $error("wake pulse longer than one cycle");
   a_no_wake_active: assert property (@(posedge core_clk) disable iff (reset)
      active |=> !wake_out)
      else $error("wake pulse while already active");
endmodule // ltc_core

// >>> common/ltc_pkg.sv
/*
   Shared constants for the LIN transceiver control block: APB register map,
   field positions, reset values and fault/wake timing counts.
   Assumes a 20 MHz core clock and 32-bit APB with word-aligned registers.
*/
package ltc_pkg;

   localparam int LTC_CLK_HZ = 20000000;

   // Timing figures in microseconds, and the derived cycle counts
   localparam int LTC_TDOM_TX_US = 20000;
   localparam int LTC_TLIN_US = 10;
   localparam int LTC_TDOM_BUS_US = 12000;
   localparam int LTC_TWAKE_DOM_US = 100;
   localparam int LTC_TLINBUS_US = 100;
   localparam int LTC_TDOM_TX_CYC = LTC_TDOM_TX_US * (LTC_CLK_HZ / 1000000);
   localparam int LTC_TLIN_CYC = LTC_TLIN_US * (LTC_CLK_HZ / 1000000);
   localparam int LTC_TDOM_BUS_CYC = LTC_TDOM_BUS_US * (LTC_CLK_HZ / 1000000);
   localparam int LTC_TWAKE_DOM_CYC = LTC_TWAKE_DOM_US * (LTC_CLK_HZ / 1000000);
   localparam int LTC_TLINBUS_CYC = LTC_TLINBUS_US * (LTC_CLK_HZ / 1000000);

   // Register byte offsets
   localparam logic [7:0] LTC_CFG_OFS = 8'h00;
   localparam logic [7:0] LTC_CTRL_OFS = 8'h04;
   localparam logic [7:0] LTC_STAT_OFS = 8'h08;
   localparam logic [7:0] LTC_CLR_OFS = 8'h0C;
   localparam logic [7:0] LTC_IEN_OFS = 8'h10;
   localparam logic [7:0] LTC_STATE_OFS = 8'h14;

   // Configuration fields
   localparam int LTC_CFG_FAST = 0;
   localparam int LTC_CFG_TOUT = 1;
   localparam int LTC_CFG_WAKE = 2;
   localparam logic [2:0] LTC_CFG_RST = 3'h2;
   // Control fields
   localparam int LTC_CTRL_RXONLY = 0;
   localparam int LTC_CTRL_STBY = 1;
   localparam int LTC_CTRL_FLASH = 2;
   localparam logic [2:0] LTC_CTRL_RST = 3'h0;
   // Status fields (also clear and enable layout)
   localparam int LTC_STS_TXDOM = 0;
   localparam int LTC_STS_PREC = 1;
   localparam int LTC_STS_PDOM = 2;
   localparam int LTC_STS_WAKE = 3;
   localparam int LTC_NSTAT = 4;

   typedef enum logic [1:0] {
      LTC_ACTIVE = 2'b00,
      LTC_STBY_REC = 2'b01,
      LTC_STBY_DOM = 2'b10
   } ltc_mode_t;

endpackage

// >>> verilog/ltc_lowcnt.sv
/*
   Saturating duration counter: counts cycles while a condition holds and
   fires once the count passes a limit. Assumes synchronous inputs.
*/
module ltc_lowcnt
   import ltc_pkg::*;
#(
   parameter int LIMIT = 16
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic run,
   output logic expired
);
   localparam int W = $clog2(LIMIT + 2);
   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;

   assign cnt_nxt = !run ? '0 : (cnt_r > W'(LIMIT)) ? cnt_r : cnt_r + 1'b1;
   assign expired = cnt_r > W'(LIMIT);

   always_ff @(posedge core_clk) begin
      if (reset) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end
endmodule // ltc_lowcnt

// >>> tb/ltc_bus_model.sv
/*
   LIN wire model: the far-side node and the pull-up.
   Assumes bus_tx and tx_drive_enable come from the control block.
*/
module ltc_bus_model (
   input wire logic bus_tx,
   input wire logic tx_drive_enable,
   input wire logic force_dom,
   input wire logic stuck_rec,
   output logic bus_rx
);
   timeunit 1ns;
   timeprecision 1ns;
   // Pull-up: recessive unless a node pulls low; stuck_rec breaks the path
   assign bus_rx = ~(force_dom | (~stuck_rec & tx_drive_enable & ~bus_tx));
endmodule // ltc_bus_model

// >>> tb/lin_transceiver_control_tb.sv
/*
   Self-checking bench for ltc_core with short fault and wake counts.
   Assumes ltc_pkg and the bus model are compiled first.
*/
module lin_transceiver_control_tb
   import ltc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk, reset, psel, penable, pwrite, pready, pslverr, txd_in, bus_rx;
   logic therm, supply, tx_drive_enable, bus_tx, rxd_out, rx_enable;
   logic fast_rate_out, wake_out, irq, force_dom, stuck_rec, er, p_rx, p_tx;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   int bad_count = 0, n_tests = 0, wake_cnt = 0, seed, w0;
   // Short counts keep every fault reachable in a few hundred cycles
   ltc_core #(.TDOM_TX_CYC(12), .TLIN_CYC(8), .TDOM_BUS_CYC(16), .TWAKE_CYC(10),
      .TLINBUS_CYC(10)) ltc_core_inst (.core_clk(core_clk), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .txd_in(txd_in), .bus_rx(bus_rx),
      .thermal_shutdown_stage_one(therm), .supply_fault(supply),
      .tx_drive_enable(tx_drive_enable), .bus_tx(bus_tx), .rxd_out(rxd_out),
      .rx_enable(rx_enable), .fast_rate_out(fast_rate_out), .wake_out(wake_out), .irq(irq));
   ltc_bus_model ltc_bus_model_inst (.bus_tx(bus_tx), .tx_drive_enable(tx_drive_enable),
      .force_dom(force_dom), .stuck_rec(stuck_rec), .bus_rx(bus_rx));
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   always @(posedge core_clk) if (wake_out === 1'b1) wake_cnt++;
   function automatic logic exp_fast(input logic [31:0] cfg, input logic [31:0] ctl);
      return cfg[LTC_CFG_FAST] | ctl[LTC_CTRL_FLASH];
   endfunction
   task cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         bad_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   // Master never assumes a latency; pready ends a wait, bounded at 20 cycles
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) chk(32'h1, 32'h0);
      rd = prdata; er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge core_clk);
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   task done(input string s);
      $display("test %s done", s);
   endtask
   task print_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      #400000;
      bad_count++;
      print_verdict;
   end
   initial begin
      seed = 32'h6A63;
      {psel, penable, pwrite, paddr, pwdata, therm, supply, force_dom, stuck_rec} = '0;
      txd_in = 1'b1; reset = 1'b1;
      cyc(8); reset <= 1'b0; cyc(3);
      chk(tx_drive_enable, 1);
      chk(rx_enable, 1);
      rdc(LTC_CFG_OFS, 32'h2);
      rdc(LTC_STATE_OFS, 32'h0);
      apb(1'b0, 8'h20, 32'h0);
      chk(rd, 32'h0);
      chk(er, 32'h1);
      for (int j = 0; j < 4; j++) begin
         apb(1'b1, LTC_CFG_OFS, 32'h2 | j[0]);
         apb(1'b1, LTC_CTRL_OFS, {j[1], 2'b00});
         chk(fast_rate_out, exp_fast(32'h2 | j[0], {j[1], 2'b00}));
      end
      apb(1'b1, LTC_CFG_OFS, 32'h2); apb(1'b1, LTC_CTRL_OFS, 32'h0); done("rate");
      cyc(1); p_rx = bus_rx; p_tx = txd_in;
      for (int i = 0; i < 40; i++) begin
         txd_in <= (i % 4 == 3) | 1'($random(seed));
         @(posedge core_clk);
         chk({rxd_out, bus_tx}, {p_rx, p_tx});
         p_rx = bus_rx; p_tx = txd_in;
      end
      txd_in <= 1'b1; done("traffic");
      apb(1'b1, LTC_CTRL_OFS, 32'h1); cyc(2);
      chk(tx_drive_enable, 0);
      force_dom <= 1'b1; cyc(3); chk(rxd_out, 0);
      force_dom <= 1'b0; apb(1'b1, LTC_CTRL_OFS, 32'h0); done("rxonly");
      txd_in <= 1'b0; cyc(18); txd_in <= 1'b1; cyc(2);
      rdc(LTC_STAT_OFS, 32'h1);
      chk({tx_drive_enable, irq}, 2'b00);
      apb(1'b1, LTC_CLR_OFS, 32'h1); cyc(3); chk(tx_drive_enable, 1);
      apb(1'b1, LTC_CFG_OFS, 32'h0); txd_in <= 1'b0; cyc(24);
      chk(tx_drive_enable, 1);
      txd_in <= 1'b1; cyc(2); rdc(LTC_STAT_OFS, 32'h4);
      apb(1'b1, LTC_CLR_OFS, 32'h4); apb(1'b1, LTC_CFG_OFS, 32'h2); done("timeout");
      apb(1'b1, LTC_IEN_OFS, 32'h2); stuck_rec <= 1'b1; txd_in <= 1'b0; cyc(12);
      txd_in <= 1'b1; stuck_rec <= 1'b0; cyc(2);
      rdc(LTC_STAT_OFS, 32'h2);
      chk({tx_drive_enable, irq}, 2'b01);
      apb(1'b1, LTC_CLR_OFS, 32'h2); cyc(3);
      chk({tx_drive_enable, irq}, 2'b10);
      for (int i = 0; i < 2; i++) begin
         therm <= (i == 0); supply <= (i == 1); cyc(3);
         chk({tx_drive_enable, rx_enable}, 2'b01);
         therm <= 1'b0; supply <= 1'b0; cyc(3); chk(tx_drive_enable, 1);
      end
      done("faults");
      apb(1'b1, LTC_IEN_OFS, 32'h8); apb(1'b1, LTC_CTRL_OFS, 32'h2);
      rdc(LTC_STATE_OFS, 32'h1); chk(bus_tx, 1);
      w0 = wake_cnt; force_dom <= 1'b1; cyc(5); force_dom <= 1'b0; cyc(4);
      chk(wake_cnt - w0, 0);
      force_dom <= 1'b1; cyc(14); force_dom <= 1'b0; cyc(6);
      chk(wake_cnt - w0, 1);
      chk(irq, 1);
      rdc(LTC_STATE_OFS, 32'h0); rdc(LTC_STAT_OFS, 32'h8);
      apb(1'b1, LTC_CLR_OFS, 32'h8); cyc(2); chk(irq, 0);
      apb(1'b1, LTC_CFG_OFS, 32'h6); apb(1'b1, LTC_CTRL_OFS, 32'h2);
      w0 = wake_cnt; force_dom <= 1'b1; cyc(14);
      chk(wake_cnt - w0, 1);
      apb(1'b1, LTC_CTRL_OFS, 32'h2); rdc(LTC_STATE_OFS, 32'h2);
      force_dom <= 1'b0; cyc(14);
      chk(wake_cnt - w0, 2);
      rdc(LTC_STATE_OFS, 32'h0); done("wake");
      print_verdict;
   end
endmodule // lin_transceiver_control_tb
